/* File: logic/addr_stepper.sv */
// next pointer value inside the write window
`default_nettype none
module addr_stepper (
    step_if.stepper s
);
    function automatic logic [8:0] bump(input logic [7:0] v, input logic [7:0] lo,
                                        input logic [7:0] hi, input logic up);
        if (up) begin
            bump = (v == hi) ? {1'b1, lo} : {1'b0, v + 8'h01};
        end else begin
            bump = (v == lo) ? {1'b1, hi} : {1'b0, v - 8'h01};
        end
    endfunction

    wire [7:0] col    = s.ptr[7:0];
    wire [7:0] line   = s.ptr[15:8];
    wire [8:0] col_b  = bump(col, s.hsa, s.hea, s.dir[0]);
    wire [8:0] line_b = bump(line, s.vsa, s.vea, s.dir[1]);

    // the slow axis moves only when the fast axis wraps at the window edge
    wire [15:0] horiz = {col_b[8] ? line_b[7:0] : line, col_b[7:0]};
    wire [15:0] vertl = {line_b[7:0], line_b[8] ? col_b[7:0] : col};

    assign s.next_ptr  = s.vert ? vertl : horiz;
    assign s.in_window = (col >= s.hsa) && (col <= s.hea)
                      && (line >= s.vsa) && (line <= s.vea);
endmodule
`default_nettype wire

/* File: logic/pixel_core_pkg.sv */
// constants and types shared by the pixel memory core
`default_nettype none
package pixel_core_pkg;
    localparam int COLS      = 176;
    localparam int LINES     = 240;
    localparam int PIX_W     = 18;
    localparam int SUB_W     = 6;
    localparam int CHANNELS  = 528;
    localparam int MEM_WORDS = COLS * LINES;
    localparam int AXI_AW    = 8;

    localparam logic [15:0] COLS_W    = 16'h00B0;
    localparam logic [7:0]  COL_LAST  = 8'hAF;
    localparam logic [7:0]  LINE_LAST = 8'hEF;
    localparam logic [7:0]  HALF_LINES = 8'h78;

    // command indices reached through the index path
    localparam logic [6:0] IDX_START_OSC = 7'h00;
    localparam logic [6:0] IDX_DRIVER    = 7'h01;
    localparam logic [6:0] IDX_ENTRY     = 7'h03;
    localparam logic [6:0] IDX_CMP1      = 7'h04;
    localparam logic [6:0] IDX_CMP2      = 7'h05;
    localparam logic [6:0] IDX_POWER     = 7'h10;
    localparam logic [6:0] IDX_ADDR_SET  = 7'h21;
    localparam logic [6:0] IDX_MEM_DATA  = 7'h22;
    localparam logic [6:0] IDX_MASK_LO   = 7'h23;
    localparam logic [6:0] IDX_MASK_HI   = 7'h24;
    localparam logic [6:0] IDX_WIN_H     = 7'h44;
    localparam logic [6:0] IDX_WIN_V     = 7'h45;

    // field positions
    localparam int SRC_REV_BIT    = 8;
    localparam int GATE_REV_BIT   = 9;
    localparam int GATE_ORDER_BIT = 10;
    localparam int COLOUR_SWAP_BIT = 12;
    localparam int DIR_LSB        = 4;
    localparam int VERT_BIT       = 3;
    localparam int STANDBY_BIT    = 0;
    localparam int EXT_CLK_BIT    = 1;

    // values after reset
    localparam logic [15:0] DRIVER_RST = 16'h0000;
    localparam logic [15:0] ENTRY_RST  = 16'h0030;
    localparam logic [15:0] WIN_H_RST  = 16'hAF00;
    localparam logic [15:0] WIN_V_RST  = 16'hEF00;
    localparam logic [15:0] POWER_RST  = 16'h0000;

    // bus offsets and answers
    localparam logic [7:0] OFF_INDEX   = 8'h00;
    localparam logic [7:0] OFF_DATA    = 8'h04;
    localparam logic [7:0] OFF_POINTER = 8'h08;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // display timing: line length in timing-generator ticks, frame length in lines
    localparam logic [7:0] LINE_TICKS  = 8'hC8;
    localparam logic [7:0] FRAME_LINES = 8'hF4;

    typedef enum logic [2:0] {
        LG_COPY   = 3'b000,
        LG_OR     = 3'b001,
        LG_AND    = 3'b010,
        LG_XOR    = 3'b011,
        LG_EQ_OLD = 3'b100,
        LG_NE_OLD = 3'b101,
        LG_EQ_NEW = 3'b110,
        LG_NE_NEW = 3'b111
    } logic_op_e;
endpackage
`default_nettype wire

/* File: logic/pixel_memory_core.sv */
// display memory access core: command decode, pointer, arbitration, line latch
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`default_nettype none
module pixel_memory_core (
    // clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    // register bus, write side
    input  wire logic                          awvalid,
    output logic                               awready,
    input  wire logic [pixel_core_pkg::AXI_AW-1:0] awaddr,
    input  wire logic                          wvalid,
    output logic                               wready,
    input  wire logic [31:0]                   wdata,
    input  wire logic [3:0]                    wstrb,
    output logic                               bvalid,
    input  wire logic                          bready,
    output logic [1:0]                         bresp,
    // register bus, read side
    input  wire logic                          arvalid,
    output logic                               arready,
    input  wire logic [pixel_core_pkg::AXI_AW-1:0] araddr,
    output logic                               rvalid,
    input  wire logic                          rready,
    output logic [31:0]                        rdata,
    output logic [1:0]                         rresp,
    // external clock pulses
    input  wire logic                          ext_clk_pin,
    // panel side
    output logic                               frame_start_marker,
    output logic [pixel_core_pkg::LINES-1:0]   gate_outputs,
    output logic [pixel_core_pkg::CHANNELS*pixel_core_pkg::SUB_W-1:0] source_outputs,
    output logic                               standby_active
);
    localparam int PW = pixel_core_pkg::PIX_W;
    localparam int SW = pixel_core_pkg::SUB_W;
    localparam int CH = pixel_core_pkg::CHANNELS;

    function automatic logic [15:0] mem_index(input logic [15:0] p);
        mem_index = {8'h00, p[15:8]} * pixel_core_pkg::COLS_W + {8'h00, p[7:0]};
    endfunction

    function automatic logic in_range(input logic [15:0] p);
        in_range = (p[7:0] <= pixel_core_pkg::COL_LAST)
                && (p[15:8] <= pixel_core_pkg::LINE_LAST);
    endfunction

    function automatic logic [7:0] gate_index(input logic [7:0] row, input logic order,
                                              input logic rev);
        logic [7:0] g;
        logic [7:0] upper;
        upper = row - pixel_core_pkg::HALF_LINES;
        g = row;
        if (order) begin
            g = (row < pixel_core_pkg::HALF_LINES) ? {row[6:0], 1'b0} : {upper[6:0], 1'b1};
        end
        gate_index = rev ? pixel_core_pkg::LINE_LAST - g : g;
    endfunction

    function automatic logic [PW-1:0] merge(input pixel_core_pkg::logic_op_e op,
                                            input logic [PW-1:0] nw, input logic [PW-1:0] old,
                                            input logic [PW-1:0] cmp, input logic [PW-1:0] mask);
        logic [PW-1:0] r;
        logic          keep;
        r = nw;
        keep = 1'b0;
        case (op)
            pixel_core_pkg::LG_COPY:   r = nw;
            pixel_core_pkg::LG_OR:     r = nw | old;
            pixel_core_pkg::LG_AND:    r = nw & old;
            pixel_core_pkg::LG_XOR:    r = nw ^ old;
            pixel_core_pkg::LG_EQ_OLD: keep = (old != cmp);
            pixel_core_pkg::LG_NE_OLD: keep = (old == cmp);
            pixel_core_pkg::LG_EQ_NEW: keep = (nw != cmp);
            pixel_core_pkg::LG_NE_NEW: keep = (nw == cmp);
            default:                   r = nw;
        endcase
        // a set mask bit protects the stored bit
        merge = keep ? old : ((r & ~mask) | (old & mask));
    endfunction

    // control state
    logic [6:0]  index_reg;
    logic [15:0] driver_reg;
    logic [15:0] entry_reg;
    logic [15:0] cmp1_reg;
    logic [15:0] cmp2_reg;
    logic [15:0] power_reg;
    logic [15:0] mask_lo_reg;
    logic [15:0] mask_hi_reg;
    logic [15:0] win_h_reg;
    logic [15:0] win_v_reg;
    logic [15:0] ptr_reg;
    logic [PW-1:0] write_staging_reg;
    logic [PW-1:0] read_staging_reg;
    logic        wr_pend_reg;
    logic        rd_pend_reg;

    // bus state
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_word_reg;
    logic        awready_reg;
    logic        wready_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        arready_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;

    // timing generator state
    logic        ext_s1_reg;
    logic        ext_s2_reg;
    logic        ext_s3_reg;
    logic        ext_level_reg;
    logic        div_reg;
    logic [7:0]  dot_reg;
    logic [7:0]  line_reg;
    logic        marker_reg;
    logic [pixel_core_pkg::LINES-1:0] gate_reg;
    logic [CH*SW-1:0] source_reg;

    logic [PW-1:0] frame_mem [pixel_core_pkg::MEM_WORDS];
    logic [PW-1:0] gather [pixel_core_pkg::COLS];

    step_if st ();
    addr_stepper u_stepper (
        .s (st.stepper)
    );
    assign st.ptr  = ptr_reg;
    assign st.dir  = entry_reg[pixel_core_pkg::DIR_LSB +: 2];
    assign st.vert = entry_reg[pixel_core_pkg::VERT_BIT];
    assign st.hsa  = win_h_reg[7:0];
    assign st.hea  = win_h_reg[15:8];
    assign st.vsa  = win_v_reg[7:0];
    assign st.vea  = win_v_reg[15:8];

    // byte lanes without a strobe read as zero
    wire [31:0] lane_mask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
    wire        aw_fire   = awvalid && awready_reg;
    wire        w_fire    = wvalid && wready_reg;
    wire        ar_fire   = arvalid && arready_reg;
    wire        join_now  = aw_held_reg && w_held_reg && !bvalid_reg;
    wire        to_index  = (aw_addr_reg == pixel_core_pkg::OFF_INDEX);
    wire        to_data   = (aw_addr_reg == pixel_core_pkg::OFF_DATA);
    wire [15:0] word      = w_word_reg[15:0];
    wire        rd_status = (araddr == pixel_core_pkg::OFF_INDEX);
    wire        rd_data   = (araddr == pixel_core_pkg::OFF_DATA);
    wire        rd_ptr    = (araddr == pixel_core_pkg::OFF_POINTER);
    wire        rd_mem    = rd_data && (index_reg == pixel_core_pkg::IDX_MEM_DATA);

    // timing tick: halved internal clock, which standby stops, or external pulses
    wire ext_mode = power_reg[pixel_core_pkg::EXT_CLK_BIT];
    wire standby  = power_reg[pixel_core_pkg::STANDBY_BIT];
    wire ext_rise = (ext_s2_reg == ext_s3_reg) && ext_s2_reg && !ext_level_reg;
    wire tick     = ext_mode ? ext_rise : (div_reg && !standby);
    wire line_end = (dot_reg == pixel_core_pkg::LINE_TICKS - 8'h01);
    wire vis_line = (line_reg <= pixel_core_pkg::LINE_LAST);
    wire disp_read = tick && vis_line && (dot_reg <= pixel_core_pkg::COL_LAST);
    wire host_slot = !disp_read;
    wire [15:0] disp_idx = mem_index({line_reg, dot_reg});

    wire [15:0] host_idx = mem_index(ptr_reg);
    wire [PW-1:0] old_pix = frame_mem[host_idx];
    wire [PW-1:0] cmp_val = {cmp2_reg[5:0], cmp1_reg[13:8], cmp1_reg[5:0]};
    wire [PW-1:0] mask_val = {mask_hi_reg[1:0], mask_lo_reg};
    wire [PW-1:0] new_pix = merge(pixel_core_pkg::logic_op_e'(entry_reg[2:0]),
                                  write_staging_reg, old_pix, cmp_val, mask_val);
    wire host_write = host_slot && wr_pend_reg && in_range(ptr_reg) && st.in_window;
    wire host_fetch = host_slot && !wr_pend_reg && rd_pend_reg;

    // source channel mapping of the gathered line
    wire src_rev = driver_reg[pixel_core_pkg::SRC_REV_BIT];
    wire swap    = entry_reg[pixel_core_pkg::COLOUR_SWAP_BIT];
    logic [SW-1:0] chan_val [CH];
    logic [CH*SW-1:0] line_flat;
    genvar gi, gj, gk;
    generate
        for (gi = 0; gi < pixel_core_pkg::COLS; gi++) begin : g_pix
            for (gj = 0; gj < 3; gj++) begin : g_sub
                assign chan_val[3*gi+gj] = swap ? gather[gi][SW*gj +: SW]
                                                : gather[gi][PW-1-SW*gj -: SW];
            end
        end
        for (gk = 0; gk < CH; gk++) begin : g_chan
            assign line_flat[gk*SW +: SW] = src_rev ? chan_val[CH-1-gk] : chan_val[gk];
        end
    endgenerate

    wire [7:0] gate_sel = gate_index(line_reg, driver_reg[pixel_core_pkg::GATE_ORDER_BIT],
                                     driver_reg[pixel_core_pkg::GATE_REV_BIT]);
    wire [pixel_core_pkg::LINES-1:0] gate_one =
        {{(pixel_core_pkg::LINES-1){1'b0}}, 1'b1} << gate_sel;

    // memory port: display has priority, host only in free slots
    always_ff @(posedge ref_clk) begin
        if (disp_read) begin
            gather[dot_reg] <= frame_mem[disp_idx];
        end
        if (host_write) begin
            frame_mem[host_idx] <= new_pix;
        end
    end

    // external clock pin: three stages, a change counts once the last two agree
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ext_s1_reg    <= 1'b0;
            ext_s2_reg    <= 1'b0;
            ext_s3_reg    <= 1'b0;
            ext_level_reg <= 1'b0;
        end else begin
            ext_s1_reg <= ext_clk_pin;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
            if (ext_s2_reg == ext_s3_reg) begin
                ext_level_reg <= ext_s2_reg;
            end
        end
    end

    // timing generator
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_reg    <= 1'b0;
            dot_reg    <= 8'h00;
            line_reg   <= 8'h00;
            marker_reg <= 1'b0;
            gate_reg   <= '0;
            source_reg <= '0;
        end else begin
            div_reg    <= !div_reg && !standby;
            marker_reg <= tick && line_end && (line_reg == pixel_core_pkg::FRAME_LINES - 8'h01);
            if (tick) begin
                dot_reg <= line_end ? 8'h00 : dot_reg + 8'h01;
                if (line_end) begin
                    line_reg <= (line_reg == pixel_core_pkg::FRAME_LINES - 8'h01) ? 8'h00
                                                                                 : line_reg + 8'h01;
                    if (vis_line) begin
                        source_reg <= line_flat;
                        gate_reg   <= gate_one;
                    end else begin
                        gate_reg <= '0;
                    end
                end
            end
        end
    end

    // command decode, pointer and bus handshakes
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            index_reg         <= 7'h00;
            driver_reg        <= pixel_core_pkg::DRIVER_RST;
            entry_reg         <= pixel_core_pkg::ENTRY_RST;
            cmp1_reg          <= 16'h0000;
            cmp2_reg          <= 16'h0000;
            power_reg         <= pixel_core_pkg::POWER_RST;
            mask_lo_reg       <= 16'h0000;
            mask_hi_reg       <= 16'h0000;
            win_h_reg         <= pixel_core_pkg::WIN_H_RST;
            win_v_reg         <= pixel_core_pkg::WIN_V_RST;
            ptr_reg           <= 16'h0000;
            write_staging_reg <= '0;
            read_staging_reg  <= '0;
            wr_pend_reg       <= 1'b0;
            rd_pend_reg       <= 1'b0;
            aw_held_reg       <= 1'b0;
            w_held_reg        <= 1'b0;
            aw_addr_reg       <= 8'h00;
            w_word_reg        <= 32'h0000_0000;
            awready_reg       <= 1'b0;
            wready_reg        <= 1'b0;
            bvalid_reg        <= 1'b0;
            bresp_reg         <= pixel_core_pkg::RESP_OKAY;
            arready_reg       <= 1'b0;
            rvalid_reg        <= 1'b0;
            rdata_reg         <= 32'h0000_0000;
            rresp_reg         <= pixel_core_pkg::RESP_OKAY;
        end else begin
            // pending memory work runs in free slots; the pointer steps after it
            if (host_slot && wr_pend_reg) begin
                wr_pend_reg <= 1'b0;
                ptr_reg     <= st.next_ptr;
            end else if (host_fetch) begin
                rd_pend_reg      <= 1'b0;
                read_staging_reg <= in_range(ptr_reg) ? frame_mem[host_idx] : '0;
                ptr_reg          <= st.next_ptr;
            end

            if (aw_fire) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= awaddr;
                awready_reg <= 1'b0;
            end
            if (w_fire) begin
                w_held_reg <= 1'b1;
                w_word_reg <= wdata & lane_mask;
                wready_reg <= 1'b0;
            end
            // new writes wait until earlier memory work is done
            if (!awready_reg && !aw_held_reg && !bvalid_reg && !wr_pend_reg && !rd_pend_reg) begin
                awready_reg <= 1'b1;
                wready_reg  <= 1'b1;
            end

            if (join_now) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= (to_index || to_data) ? pixel_core_pkg::RESP_OKAY
                                                     : pixel_core_pkg::RESP_SLVERR;
                if (to_index) begin
                    index_reg <= word[6:0];
                end else if (to_data) begin
                    case (index_reg)
                        pixel_core_pkg::IDX_START_OSC:
                            if (word[0]) power_reg[pixel_core_pkg::STANDBY_BIT] <= 1'b0;
                        pixel_core_pkg::IDX_DRIVER:   driver_reg  <= word;
                        pixel_core_pkg::IDX_ENTRY:    entry_reg   <= word;
                        pixel_core_pkg::IDX_CMP1:     cmp1_reg    <= word;
                        pixel_core_pkg::IDX_CMP2:     cmp2_reg    <= word;
                        pixel_core_pkg::IDX_POWER:    power_reg   <= word;
                        pixel_core_pkg::IDX_MASK_LO:  mask_lo_reg <= word;
                        pixel_core_pkg::IDX_MASK_HI:  mask_hi_reg <= word;
                        pixel_core_pkg::IDX_WIN_H:    win_h_reg   <= word;
                        pixel_core_pkg::IDX_WIN_V:    win_v_reg   <= word;
                        pixel_core_pkg::IDX_ADDR_SET: ptr_reg     <= word;
                        pixel_core_pkg::IDX_MEM_DATA: begin
                            write_staging_reg <= w_word_reg[PW-1:0];
                            wr_pend_reg       <= 1'b1;
                        end
                        default: ;
                    endcase
                end
            end
            if (bvalid_reg && bready) begin
                bvalid_reg <= 1'b0;
            end

            if (ar_fire) begin
                arready_reg <= 1'b0;
                rvalid_reg  <= 1'b1;
                rresp_reg   <= (rd_status || rd_data || rd_ptr) ? pixel_core_pkg::RESP_OKAY
                                                                : pixel_core_pkg::RESP_SLVERR;
                rdata_reg   <= 32'h0000_0000;
                if (rd_status) begin
                    rdata_reg <= {16'h0000, line_reg, 8'h00};
                end else if (rd_mem) begin
                    // the holder answers now and is refilled afterwards
                    rdata_reg   <= {14'h0000, read_staging_reg};
                    rd_pend_reg <= 1'b1;
                end else if (rd_ptr) begin
                    rdata_reg <= {14'h0000, wr_pend_reg, rd_pend_reg, ptr_reg};
                end
            end
            if (rvalid_reg && rready) begin
                rvalid_reg <= 1'b0;
            end
            if (!arready_reg && !rvalid_reg && !rd_pend_reg && !ar_fire) begin
                arready_reg <= 1'b1;
            end
        end
    end

    assign awready            = awready_reg;
    assign wready             = wready_reg;
    assign bvalid             = bvalid_reg;
    assign bresp              = bresp_reg;
    assign arready            = arready_reg;
    assign rvalid             = rvalid_reg;
    assign rdata              = rdata_reg;
    assign rresp              = rresp_reg;
    assign frame_start_marker = marker_reg;
    assign gate_outputs       = gate_reg;
    assign source_outputs     = source_reg;
    assign standby_active     = power_reg[pixel_core_pkg::STANDBY_BIT];
endmodule
`default_nettype wire

/* File: logic/step_if.sv */
// pointer stepping signals between the core and its stepper
`default_nettype none
interface step_if;
    logic [15:0] ptr;
    logic [1:0]  dir;
    logic        vert;
    logic [7:0]  hsa;
    logic [7:0]  hea;
    logic [7:0]  vsa;
    logic [7:0]  vea;
    logic [15:0] next_ptr;
    logic        in_window;
    modport stepper (input ptr, dir, vert, hsa, hea, vsa, vea,
                     output next_ptr, in_window);
    modport user (output ptr, dir, vert, hsa, hea, vsa, vea,
                  input next_ptr, in_window);
endinterface
`default_nettype wire

/* File: tb/core_checker_assertions.sv */
// bus and panel timing checks for the pixel memory core
`default_nettype none
module core_checker (
    input wire logic ref_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready,
    input wire logic arvalid, arready, rvalid, rready, frame_start_marker,
    input wire logic [1:0] bresp, rresp,
    input wire logic [31:0] rdata,
    input wire logic [pixel_core_pkg::LINES-1:0] gate_outputs
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_bresp_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped early");
    a_rdata_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer dropped early");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write answer late");
    a_take_blocks: assert property (awvalid && awready |=> !awready)
        else $error("second write taken");
    a_frame_pulse: assert property (frame_start_marker |=> !frame_start_marker)
        else $error("frame marker too long");
    a_gate_onehot: assert property ($onehot0(gate_outputs))
        else $error("two gates driven");
    a_resp_legal: assert property (rvalid |-> rresp == 2'b00 || rresp == 2'b10)
        else $error("bad read response");
    cover property (bvalid && bresp == 2'b10);
    cover property (rvalid && rready);
    cover property (frame_start_marker);
endmodule
bind pixel_memory_core core_checker u_core_checker (.*);
`default_nettype wire

/* File: tb/host_bus_model.sv */
// host side bus master: one transfer per go pulse
`default_nettype none
module host_bus_model (
    input wire logic ref_clk, go, we, awready, wready, bvalid, arready, rvalid,
    input wire logic [7:0] addr,
    input wire logic [31:0] wd, rdata,
    input wire logic [1:0] bresp, rresp,
    output logic done, awvalid, wvalid, bready, arvalid, rready,
    output logic [7:0] awaddr, araddr,
    output logic [31:0] rd, wdata,
    output logic [3:0] wstrb,
    output logic [1:0] resp
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {done, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    assign wstrb = 4'hF;
    // each valid is held until its ready is sampled, and bready and rready until their valid
    always @(posedge ref_clk) begin
        done <= 1'b0;
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (arvalid && arready) arvalid <= 1'b0;
        if (bready && bvalid) {bready, resp, done} <= {1'b0, bresp, 1'b1};
        if (rready && rvalid) {rready, resp, rd, done} <= {1'b0, rresp, rdata, 1'b1};
        if (go && we) {awvalid, wvalid, bready, awaddr, wdata} <= {3'h7, addr, wd};
        if (go && !we) {arvalid, rready, araddr} <= {2'h3, addr};
    end
endmodule
`default_nettype wire

/* File: tb/pixel_frame_memory_address_counter_map_tb_top.sv */
// command, pointer and memory access tests of the pixel memory core
`default_nettype none
module pixel_frame_memory_address_counter_map_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0, rst, go, we, done, ext_clk_pin, frame_start_marker, standby_active;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] addr, awaddr, araddr;
    logic [31:0] wd, rd, wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] resp, bresp, rresp;
    logic [239:0] gate_outputs;
    logic [3167:0] source_outputs;
    int fails = 0, compares = 0;
    logic [7:0] ln;
    pixel_memory_core u_pixel_memory_core (.*);
    host_bus_model u_host_bus_model (.*);
    always #50 ref_clk = ~ref_clk;
    task conclude();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk) {go, we, addr, wd} <= {1'b1, w, a, d};
        @(posedge ref_clk) go <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 99) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 99) begin
            fails++;
            $display("ERROR %0t bus timeout", $time);
            conclude();
        end
    endtask
    // a line reaches the panel once its gate is driven; three lines take about 1200 cycles
    task wait_gate(input logic [7:0] g);
        int n;
        n = 0;
        while (gate_outputs[g] !== 1'b1 && n < 2000) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 2000) begin
            fails++;
            $display("ERROR %0t gate wait timeout", $time);
            conclude();
        end
    endtask
    task cmd(input logic [7:0] idx, input logic [31:0] v);
        xfer(1'b1, 8'h00, {24'h0, idx});
        xfer(1'b1, 8'h04, v);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] r);
        xfer(1'b0, a, 32'h0);
        check(rd & m, e);
        check(32'(resp), 32'(r));
    endtask
    initial begin
        {rst, go, we, addr, wd, ext_clk_pin} = {1'b1, 43'h0};
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        cmd(8'h21, 32'h0005);
        rdc(8'h08, 32'hFFFF, 32'h0005, 2'b00);
        cmd(8'h22, 32'h3FFFF);
        xfer(1'b1, 8'h04, 32'h12345);
        rdc(8'h08, 32'hFFFF, 32'h0007, 2'b00);
        // first read after addressing only primes the holder
        cmd(8'h21, 32'h0005);
        xfer(1'b1, 8'h00, 32'h22);
        xfer(1'b0, 8'h04, 32'h0);
        rdc(8'h04, 32'h3FFFF, 32'h3FFFF, 2'b00);
        rdc(8'h04, 32'h3FFFF, 32'h12345, 2'b00);
        cmd(8'h44, 32'h0706);
        cmd(8'h21, 32'h0007);
        cmd(8'h22, 32'h1);
        rdc(8'h08, 32'hFFFF, 32'h0106, 2'b00);
        xfer(1'b1, 8'h0C, 32'h1);
        check(32'(resp), 32'h2);
        rdc(8'h0C, 32'hFFFFFFFF, 32'h0, 2'b10);
        rdc(8'h00, 32'hFF, 32'h0, 2'b00);
        cmd(8'h10, 32'h1);
        check(32'(standby_active), 32'h1);
        cmd(8'h00, 32'h1);
        check(32'(standby_active), 32'h0);
        // pixel with red 01, green 02, blue 03 lands two lines ahead of the scan
        cmd(8'h44, 32'hAF00);
        xfer(1'b0, 8'h00, 32'h0);
        ln = rd[15:8] + 8'h02;
        cmd(8'h21, {16'h0, ln, 8'h00});
        cmd(8'h22, 32'h01083);
        wait_gate(ln);
        check(32'(source_outputs[17:0]), 32'h03081);
        // mirrored order: last column feeds the first channels, red first
        cmd(8'h01, 32'h0100);
        cmd(8'h03, 32'h1030);
        cmd(8'h21, {16'h0, ln + 8'h02, 8'hAF});
        cmd(8'h22, 32'h01083);
        wait_gate(ln + 8'h02);
        check(32'(source_outputs[17:0]), 32'h03081);
        conclude();
    end
endmodule
`default_nettype wire
